// ===== design/cis_line_scan_sequencer.sv
`timescale 1ns/1ns
module cis_line_scan_sequencer
  import cis_line_scan_pkg::*;
#(
  parameter int unsigned PIXELS_PER_CHIP_P = PIXELS_PER_CHIP,
  parameter int unsigned CHIPS_FULL_P = CHIPS_FULL_SECTION,
  parameter int unsigned CHIPS_SHORT_P = CHIPS_SHORT_SECTION
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic pixel_sampling_clock_i,
  input wire logic line_start_pulse_i,
  output logic line_start_o,
  output logic [SECTION_COUNT-1:0] pixel_valid_o,
  output logic [PIXEL_INDEX_W-1:0] pixel_index_o,
  output logic line_done_o
);

  // ********************************
  // parameter checks
  // ********************************
  localparam int unsigned FULL_LEN = PIXELS_PER_CHIP_P * CHIPS_FULL_P;
  localparam int unsigned SHORT_LEN = PIXELS_PER_CHIP_P * CHIPS_SHORT_P;

  // the index must reach the last pixel of a full section
  if (FULL_LEN > (1 << PIXEL_INDEX_W))
  begin
    $error("full section longer than the pixel index can count");
  end
  if (SHORT_LEN == 0)
  begin
    $error("section four needs at least one chip");
  end
  if (SHORT_LEN >= FULL_LEN)
  begin
    $error("section four must be shorter than the other sections");
  end

  // ********************************
  // reset release
  // ********************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic nxt_rst_meta;
  logic nxt_rst_sync;

  // entry is immediate; release waits two edges so no flop sees it near the clock
  always_comb
  begin
    nxt_rst_meta = 1'b1;
    nxt_rst_sync = rst_meta_ff;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= nxt_rst_meta;
      rst_sync_ff <= nxt_rst_sync;
    end
  end

  // ********************************
  // sequencer
  // ********************************
  localparam logic [PIXEL_INDEX_W-1:0] LAST_FULL = PIXEL_INDEX_W'(FULL_LEN - 1);
  localparam int unsigned COUNT_W = PIXEL_INDEX_W + 1;
  localparam logic [COUNT_W-1:0] FULL_COUNT = COUNT_W'(FULL_LEN);
  localparam logic [COUNT_W-1:0] SHORT_COUNT = COUNT_W'(SHORT_LEN);

  // pixels that a section delivers in one line; the last section holds one chip less
  function automatic logic [COUNT_W-1:0] section_length(input int unsigned section);
    logic [COUNT_W-1:0] len;
    if (section == SECTION_COUNT - 1)
      len = SHORT_COUNT;
    else
      len = FULL_COUNT;
    return len;
  endfunction

  // all sections move on the same sampling period, so one index serves all four
  function automatic logic [SECTION_COUNT-1:0] sections_live(input logic [PIXEL_INDEX_W-1:0] index);
    logic [SECTION_COUNT-1:0] live;
    live = '0;
    for (int unsigned k = 0; k < SECTION_COUNT; k++)
    begin
      live[k] = {1'b0, index} < section_length(k);
    end
    return live;
  endfunction

  // ********************************
  // sampling clock edges
  // ********************************
  // sampling clock is a plain synchronous input, so edges are detected against the
  // previous sample; its high and low phases must each span a clk_i cycle with clk_en_i high
  logic samp_clk_ff;
  logic nxt_samp_clk;
  logic rise;
  logic take_start;
  logic take_step;

  always_comb
  begin
    nxt_samp_clk = pixel_sampling_clock_i;
    // falling edges are never looked at for a start
    rise = pixel_sampling_clock_i && !samp_clk_ff;
    take_start = rise && line_start_pulse_i;
    take_step = rise && !line_start_pulse_i;
  end

  always_ff @(posedge clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      samp_clk_ff <= EDGE_HISTORY_RESET[0];
    end
    else if (clk_en_i)
    begin
      samp_clk_ff <= nxt_samp_clk;
    end
  end

  // ********************************
  // scan position
  // ********************************
  scan_state_t state_ff;
  scan_state_t nxt_state;
  logic [PIXEL_INDEX_W-1:0] index_ff;
  logic [PIXEL_INDEX_W-1:0] nxt_index;
  logic [SECTION_COUNT-1:0] valid_ff;
  logic [SECTION_COUNT-1:0] nxt_valid;
  logic line_end;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_index = index_ff;
    nxt_valid = valid_ff;
    line_end = 1'b0;
    if (take_start)
    begin
      // a new start re-arms the chain even mid-line; rst_n_i is the only other reset
      nxt_state = SCAN_ACTIVE;
      nxt_index = PIXEL_INDEX_RESET;
      nxt_valid = sections_live(PIXEL_INDEX_RESET);
    end
    else if (take_step)
    begin
      case (state_ff)
        SCAN_IDLE:
        begin
          nxt_valid = '0;
        end
        SCAN_ACTIVE:
        begin
          // one pixel per sampling period on each section whose valid bit is set
          if (index_ff == LAST_FULL)
          begin
            nxt_state = SCAN_IDLE;
            nxt_valid = '0;
            line_end = 1'b1;
          end
          else
          begin
            nxt_index = index_ff + PIXEL_INDEX_W'(1);
            // section four runs out one chip early
            nxt_valid = sections_live(nxt_index);
          end
        end
        default:
        begin
          nxt_state = SCAN_IDLE;
          nxt_valid = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      state_ff <= SCAN_IDLE;
      index_ff <= PIXEL_INDEX_RESET;
      valid_ff <= '0;
    end
    else if (clk_en_i)
    begin
      state_ff <= nxt_state;
      index_ff <= nxt_index;
      valid_ff <= nxt_valid;
    end
  end

  // ********************************
  // line pulses
  // ********************************
  logic start_ff;
  logic nxt_start;
  logic done_ff;
  logic nxt_done;

  always_comb
  begin
    // one enabled cycle each; a frozen clock enable stretches them
    nxt_start = take_start;
    nxt_done = line_end;
  end

  always_ff @(posedge clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      start_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      start_ff <= nxt_start;
      done_ff <= nxt_done;
    end
  end

  assign line_start_o = start_ff;
  assign pixel_valid_o = valid_ff;
  assign pixel_index_o = index_ff;
  assign line_done_o = done_ff;

endmodule

// ===== design/cis_line_scan_pkg.sv
package cis_line_scan_pkg;

  // ********************************
  // geometry
  // ********************************
  localparam int unsigned PIXELS_PER_CHIP = 128;
  localparam int unsigned CHIPS_FULL_SECTION = 7;
  localparam int unsigned CHIPS_SHORT_SECTION = 6;
  localparam int unsigned SECTION_COUNT = 4;
  localparam int unsigned PIXEL_INDEX_W = 10;

  // ********************************
  // reset values
  // ********************************
  localparam logic [PIXEL_INDEX_W-1:0] PIXEL_INDEX_RESET = 10'h000;
  localparam logic [1:0] EDGE_HISTORY_RESET = 2'h0;

  typedef enum logic [0:0] {
    SCAN_IDLE,
    SCAN_ACTIVE
  } scan_state_t;

endpackage

// ===== tb/scan_ctrl_model.sv
`timescale 1ns/1ns
module scan_ctrl_model (
  input logic clk_i,
  input logic en_i,
  input logic go_i,
  input logic bad_i,
  output logic smp_o = 1'h0,
  output logic start_o = 1'h0
);
  // a wanted start rises with the sampling clock and covers one rise only; a stray
  // one fills just a low phase, so no start spans two rises or two falls
  always @(negedge clk_i)
    if (en_i)
    begin
      start_o <= smp_o ? bad_i : go_i;
      smp_o <= !smp_o;
    end
endmodule

// ===== tb/seq_asserts.sv
`timescale 1ns/1ns
module seq_asserts
  import cis_line_scan_pkg::*;
#(parameter int unsigned PIXELS_PER_CHIP_P = 128)
(
  input logic clk_i,
  input logic rst_n_i,
  input logic clk_en_i,
  input logic pixel_sampling_clock_i,
  input logic line_start_pulse_i,
  input logic line_start_o,
  input logic [SECTION_COUNT-1:0] pixel_valid_o,
  input logic [PIXEL_INDEX_W-1:0] pixel_index_o,
  input logic line_done_o
);
  logic prev_ff;
  logic rise;
  logic step;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      prev_ff <= 1'h0;
    else if (clk_en_i)
      prev_ff <= pixel_sampling_clock_i;
  assign rise = clk_en_i & pixel_sampling_clock_i & ~prev_ff;
  assign step = rise & ~line_start_pulse_i & pixel_valid_o[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  line_start_a: assert property (rise & line_start_pulse_i |=>
    line_start_o && pixel_valid_o == 4'hf && pixel_index_o == 10'h0) else $error("no start");
  false_start_a: assert property (clk_en_i & !(rise & line_start_pulse_i) |=> !line_start_o)
    else $error("false start");
  index_step_a: assert property (step && pixel_index_o < PIXELS_PER_CHIP_P*7-1 |=>
    pixel_index_o == $past(pixel_index_o) + 10'h1) else $error("bad step");
  short_section_a: assert property (step && pixel_index_o == PIXELS_PER_CHIP_P*6-1 |=>
    pixel_valid_o == 4'h7) else $error("bad short");
  line_end_a: assert property (step && pixel_index_o == PIXELS_PER_CHIP_P*7-1 |=>
    line_done_o && pixel_valid_o == 4'h0) else $error("bad end");
  output_hold_a: assert property (!rise |=> $stable(pixel_valid_o) && $stable(pixel_index_o))
    else $error("moved");
  section_match_a: assert property (pixel_valid_o[2:0] == 3'h0 || pixel_valid_o[2:0] == 3'h7)
    else $error("sections apart");
  short_inside_a: assert property (!pixel_valid_o[3] || pixel_valid_o[0])
    else $error("section four outlives section one");
  done_pulse_a: assert property (line_done_o && clk_en_i |=> !line_done_o)
    else $error("long done");
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import cis_line_scan_pkg::*;
  localparam int P = 4;
  logic clk = 0, rst_n = 0, en = 0, go = 0, bad = 0, smp, strt, ls, ld;
  logic [3:0] v;
  logic [9:0] ix;
  int n_errors = 0, n_tests = 0, cyc = 0, ei = 0, ev = 0;
  bit el, ed, ep, rdy, chk;
  initial forever #2 clk = ~clk;
  cis_line_scan_sequencer #(.PIXELS_PER_CHIP_P(P)) cis_line_scan_sequencer_inst (.clk_i(clk), .rst_n_i(rst_n),
    .clk_en_i(en), .pixel_sampling_clock_i(smp), .line_start_pulse_i(strt), .line_start_o(ls),
    .pixel_valid_o(v), .pixel_index_o(ix), .line_done_o(ld));
  scan_ctrl_model scan_ctrl_model_inst (.clk_i(clk), .en_i(en), .go_i(go), .bad_i(bad), .smp_o(smp),
    .start_o(strt));
  task automatic check(input logic [15:0] s, e);
    n_tests++;
    if (s !== e)
      $display("BAD out exp %h got %h", e, s);
    n_errors += int'(s !== e);
  endtask
  task automatic give_verdict(input int t);
    n_errors += t;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // pulses may stand through a frozen cycle, so only enabled cycles are compared
  always @(posedge clk)
  begin
    chk = en & rdy;
    {el, ed} = 2'h0;
    if (en && smp && !ep && strt)
      {el, ei, ev} = {1'b1, 32'h0, 32'hf};
    else if (en && smp && !ep && ev != 0)
    begin
      ed = ei == P*CHIPS_FULL_SECTION-1;
      ev = ed ? 0 : ei == P*CHIPS_SHORT_SECTION-1 ? 7 : ev;
      ei = ed ? ei : ei+1;
    end
    ep = en ? smp : ep;
    if (cyc++ == 8000)
      give_verdict(1);
  end
  always @(negedge clk)
  begin
    en <= rdy ? $urandom_range(7) != 0 : en;
    if (chk)
      check({ls, ld, v, ix}, {el, ed, 4'(ev), 10'(ei)});
  end
  initial
  begin
    void'($urandom(28667));
    repeat (6) @(negedge clk);
    rst_n <= 1;
    repeat (4) @(negedge clk);
    rdy <= 1;
    for (int i = 0; i < 12; i++)
    begin
      {go, bad} <= {1'b1, i[0]};
      do @(negedge clk); while (!(strt && smp));
      go <= 0;
      repeat ($urandom_range(150, 20)) @(negedge clk);
    end
    give_verdict(0);
  end
endmodule
bind cis_line_scan_sequencer seq_asserts #(.PIXELS_PER_CHIP_P(PIXELS_PER_CHIP_P)) seq_asserts_inst (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .pixel_sampling_clock_i(pixel_sampling_clock_i),
  .line_start_pulse_i(line_start_pulse_i), .line_start_o(line_start_o), .pixel_valid_o(pixel_valid_o),
  .pixel_index_o(pixel_index_o), .line_done_o(line_done_o));
